// >>> core/bsr_pkg.sv
// Package for the boot status record block: addresses, field layout, states
`default_nettype none
package bsr_pkg;
    // Unified code/data RAM
    localparam int BSR_RAM_AW = 13;
    localparam logic [12:0] BSR_RAM_FIRST = 13'h0000;
    localparam logic [12:0] BSR_RAM_LAST = 13'h11ff;
    localparam logic [12:0] BSR_CPU_START_ADDR = 13'h0000;
    // Status record locations, high byte at the lower address
    localparam logic [12:0] BSR_RESERVED_START_ADDR = 13'h11f3;
    localparam logic [12:0] BSR_USER_LOAD_START_ADDR = 13'h11f5;
    localparam logic [12:0] BSR_NVM_NEXT_ADDR = 13'h11fd;
    localparam logic [12:0] BSR_RESULT_ADDR = 13'h11ff;
    localparam logic [12:0] BSR_RECORD_FIRST = 13'h11f3;
    // Result byte fields
    localparam int BSR_PIN_BIT = 7;
    localparam int BSR_FACT_LSB = 2;
    localparam int BSR_LATER_BIT = 1;
    localparam int BSR_FIRST_BIT = 0;
    localparam logic [7:0] BSR_RESULT_OK = 8'h00;
    // Boot control register bits
    localparam int BSR_FAIL_BIT = 2;
    localparam int BSR_DONE_BIT = 1;
    // Record writer sequence
    typedef enum logic [2:0] {
        BSR_IDLE = 3'b000,
        BSR_FILL = 3'b001,
        BSR_REC = 3'b010,
        BSR_DONE = 3'b011
    } bsr_state_type;
    localparam logic [2:0] BSR_REC_WORDS = 3'h7;
endpackage
`default_nettype wire

// >>> core/bsr_ram.sv
// Unified code/data RAM with one write port and two read ports
`default_nettype none
module bsr_ram
    import bsr_pkg::*;
#(
    parameter int AW = BSR_RAM_AW,
    parameter int DEPTH = 4608
) (
    input wire logic i_sys_clk,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [7:0] i_wdata,
    input wire logic [AW-1:0] i_raddr_a,
    output logic [7:0] o_rdata_a,
    input wire logic [AW-1:0] i_raddr_b,
    output logic [7:0] o_rdata_b
);
    // Refuse a depth that the address width cannot reach
    if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_depth
        $error("bsr_ram: depth exceeds address space");
    end
    logic [7:0] mem [DEPTH];
    // Synchronous read; out-of-range reads return zero
    always_ff @(posedge i_sys_clk) begin
        if (i_we && (32'(i_waddr) < DEPTH)) mem[i_waddr] <= i_wdata;
        o_rdata_a <= (32'(i_raddr_a) < DEPTH) ? mem[i_raddr_a] : 8'h00;
        o_rdata_b <= (32'(i_raddr_b) < DEPTH) ? mem[i_raddr_b] : 8'h00;
    end
endmodule
`default_nettype wire

// >>> core/bsr_top.sv
// Boot status record writer, unified RAM ports and boot failure flag
`default_nettype none
module bsr_top
    import bsr_pkg::*;
#(
    parameter int FACTORY_BYTES = 16,
    parameter logic [12:0] RESERVED_START = 13'h11e3
) (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_pin0,
    input wire logic i_boot_end,
    input wire logic i_mission_level,
    input wire logic [15:0] i_user_load_nvm_start,
    input wire logic [15:0] i_nvm_next_unread,
    input wire logic [2:0] i_factory_load_error,
    input wire logic i_later_user_block_error,
    input wire logic i_first_user_block_error,
    input wire logic i_fill_we,
    input wire logic [12:0] i_fill_addr,
    input wire logic [7:0] i_fill_data,
    input wire logic i_cpu_we,
    input wire logic [12:0] i_cpu_data_addr,
    input wire logic [7:0] i_cpu_wdata,
    input wire logic [12:0] i_cpu_fetch_addr,
    output logic [7:0] o_cpu_rdata,
    output logic [7:0] o_cpu_fetch_data,
    output logic o_boot_failed_flag,
    output logic o_boot_complete_flag,
    output logic o_cpu_run,
    output logic [12:0] o_cpu_start_addr
);
    // Factory area must be non-empty and fit below the status record
    localparam int AREA_END = 32'(RESERVED_START) + FACTORY_BYTES;
    if (FACTORY_BYTES < 1 || AREA_END > 32'(BSR_RECORD_FIRST)) begin : g_bad_area
        $error("bsr_top: factory area overlaps status record");
    end

    // Pin synchroniser with no reset, so it carries the pin level while reset
    // is held; reset must last two edges or the early sample is stale.
    // First stage feeds only the second.
    logic pin_s1_ff, pin_s2_ff;
    always_ff @(posedge i_sys_clk) begin
        pin_s1_ff <= i_pin0;
        pin_s2_ff <= pin_s1_ff;
    end

    bsr_state_type state_ff, nxt_state;
    logic [12:0] idx_ff, nxt_idx;
    logic early_pin_sample_ff, nxt_early_pin_sample;
    logic [7:0] result_ff, nxt_result;
    logic failed_ff, nxt_failed;
    logic done_ff, nxt_done;
    logic run_ff, nxt_run;
    logic [12:0] start_ff, nxt_start;
    logic rec_we;
    logic [12:0] rec_addr;
    logic [7:0] rec_data;
    logic [7:0] factory_byte;

    // Factory defaults are a fixed pattern here; any constant table would serve
    assign factory_byte = idx_ff[7:0] ^ 8'h5a;

    // Status record byte for each offset in the record
    function automatic logic [7:0] rec_byte(input logic [2:0] k, input logic [7:0] res,
                                            input logic [15:0] ustart,
                                            input logic [15:0] nxt);
        logic [7:0] b;
        b = 8'h00;
        unique case (k)
            3'h0: b = {3'h0, RESERVED_START[12:8]};
            3'h1: b = RESERVED_START[7:0];
            3'h2: b = ustart[15:8];
            3'h3: b = ustart[7:0];
            3'h4: b = nxt[15:8];
            3'h5: b = nxt[7:0];
            3'h6: b = res;
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    // Sequence: capture pin, restore factory area, write record, release CPU
    always_comb begin
        nxt_state = state_ff;
        nxt_idx = idx_ff;
        nxt_early_pin_sample = early_pin_sample_ff;
        nxt_result = result_ff;
        nxt_failed = failed_ff;
        nxt_done = done_ff;
        nxt_run = run_ff;
        nxt_start = start_ff;
        rec_we = 1'b0;
        rec_addr = idx_ff;
        rec_data = 8'h00;
        unique case (state_ff)
            BSR_IDLE: begin
                // pin caught once at the start of boot
                nxt_early_pin_sample = pin_s2_ff;
                nxt_idx = RESERVED_START;
                nxt_state = BSR_FILL;
            end
            BSR_FILL: begin
                // factory area rebuilt after every reset
                rec_we = 1'b1;
                rec_data = factory_byte;
                if (32'(idx_ff) == 32'(RESERVED_START) + FACTORY_BYTES - 1) begin
                    nxt_state = BSR_REC;
                end else begin
                    nxt_idx = idx_ff + 13'h1;
                end
                if (nxt_state == BSR_REC && !i_boot_end) begin
                    nxt_state = BSR_FILL;
                    nxt_idx = idx_ff;
                end
                if (nxt_state == BSR_REC) begin
                    nxt_idx = BSR_RECORD_FIRST;
                    // error fields; bit 7 alone also counts as failure
                    nxt_result = BSR_RESULT_OK;
                    nxt_result[BSR_PIN_BIT] = early_pin_sample_ff;
                    nxt_result[BSR_FACT_LSB +: 3] = i_factory_load_error;
                    nxt_result[BSR_LATER_BIT] = i_later_user_block_error;
                    nxt_result[BSR_FIRST_BIT] = i_first_user_block_error;
                end
            end
            BSR_REC: begin
                // record at 0x11F3..0x11FF; words, result last
                rec_we = 1'b1;
                rec_addr = idx_ff;
                if (idx_ff >= BSR_RECORD_FIRST && idx_ff < BSR_USER_LOAD_START_ADDR)
                    rec_data = rec_byte(3'(idx_ff - BSR_RESERVED_START_ADDR), result_ff,
                                        i_user_load_nvm_start, i_nvm_next_unread);
                else if (idx_ff < BSR_USER_LOAD_START_ADDR + 13'h2)
                    rec_data = rec_byte(3'(idx_ff - BSR_USER_LOAD_START_ADDR + 13'h2),
                                        result_ff, i_user_load_nvm_start,
                                        i_nvm_next_unread);
                else if (idx_ff >= BSR_NVM_NEXT_ADDR && idx_ff < BSR_RESULT_ADDR)
                    rec_data = rec_byte(3'(idx_ff - BSR_NVM_NEXT_ADDR + 13'h4), result_ff,
                                        i_user_load_nvm_start, i_nvm_next_unread);
                else if (idx_ff == BSR_RESULT_ADDR)
                    rec_data = result_ff;
                else
                    rec_data = 8'h00;
                if (idx_ff == BSR_RESULT_ADDR) begin
                    // failure flag mirrors any nonzero result
                    nxt_failed = (result_ff != BSR_RESULT_OK);
                    nxt_done = 1'b1;
                    nxt_state = BSR_DONE;
                end else begin
                    nxt_idx = idx_ff + 13'h1;
                end
            end
            BSR_DONE: begin
                // user code released only once the record is complete
                nxt_run = i_mission_level;
                // mission parts start at address zero
                nxt_start = BSR_CPU_START_ADDR;
            end
            default: nxt_state = BSR_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_ff <= BSR_IDLE;
            idx_ff <= 13'h0000;
            early_pin_sample_ff <= 1'b0;
            result_ff <= 8'h00;
            failed_ff <= 1'b0;
            done_ff <= 1'b0;
            run_ff <= 1'b0;
            start_ff <= 13'h0000;
        end else begin
            state_ff <= nxt_state;
            idx_ff <= nxt_idx;
            early_pin_sample_ff <= nxt_early_pin_sample;
            result_ff <= nxt_result;
            failed_ff <= nxt_failed;
            done_ff <= nxt_done;
            run_ff <= nxt_run;
            start_ff <= nxt_start;
        end
    end

    // Write port owner: boot logic, then boot loader fill, then the CPU.
    // CPU writes into the reserved area are not blocked.
    logic ram_we;
    logic [12:0] ram_waddr;
    logic [7:0] ram_wdata;
    always_comb begin
        if (rec_we) begin
            ram_we = 1'b1;
            ram_waddr = rec_addr;
            ram_wdata = rec_data;
        end else if (state_ff != BSR_DONE) begin
            ram_we = i_fill_we;
            ram_waddr = i_fill_addr;
            ram_wdata = i_fill_data;
        end else begin
            ram_we = i_cpu_we && run_ff;
            ram_waddr = i_cpu_data_addr;
            ram_wdata = i_cpu_wdata;
        end
    end

    // one store serves data moves and instruction fetch
    bsr_ram #(
        .AW(BSR_RAM_AW),
        .DEPTH(32'(BSR_RAM_LAST) + 1)
    ) u_ram (
        .i_sys_clk(i_sys_clk),
        .i_we(ram_we),
        .i_waddr(ram_waddr),
        .i_wdata(ram_wdata),
        .i_raddr_a(i_cpu_data_addr),
        .o_rdata_a(o_cpu_rdata),
        .i_raddr_b(i_cpu_fetch_addr),
        .o_rdata_b(o_cpu_fetch_data)
    );

    assign o_boot_failed_flag = failed_ff;
    assign o_boot_complete_flag = done_ff;
    assign o_cpu_run = run_ff;
    assign o_cpu_start_addr = start_ff;
endmodule
`default_nettype wire

// >>> sim/bsr_top_chk.sv
// Checker for boot record timing, failure flag and processor release
`default_nettype none
module bsr_top_chk
    import bsr_pkg::*;
#(
    parameter int FACTORY_BYTES = 16
) (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_pin0,
    input wire logic i_boot_end,
    input wire logic i_mission_level,
    input wire logic [2:0] i_factory_load_error,
    input wire logic i_later_user_block_error,
    input wire logic i_first_user_block_error,
    input wire logic o_boot_failed_flag,
    input wire logic o_boot_complete_flag,
    input wire logic o_cpu_run,
    input wire logic [12:0] o_cpu_start_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    // Fill plus thirteen record bytes, with a little slack for pipeline stages
    localparam int N_LO = FACTORY_BYTES + 12;
    localparam int N_HI = FACTORY_BYTES + 17;
    logic [7:0] wait_ff;
    logic [7:0] nxt_wait;
    logic held_ff;
    logic nxt_held;
    default clocking @(posedge i_sys_clk);
    endclocking
    default disable iff (i_sys_rst);
    // Cycles since reset release; saturates so it never wraps.
    // Held marks a boot whose loader end came late; the fixed window is then void.
    always_comb begin
        nxt_wait = wait_ff;
        nxt_held = held_ff | !i_boot_end;
        if (!o_boot_complete_flag && wait_ff != 8'hff) begin
            nxt_wait = wait_ff + 8'h01;
        end
    end
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wait_ff <= 8'h00;
            held_ff <= 1'b0;
        end else begin
            wait_ff <= nxt_wait;
            held_ff <= nxt_held;
        end
    end
    sequence s_done_rise;
        $rose(o_boot_complete_flag);
    endsequence
    property p_done_time;
        s_done_rise ##0 !held_ff |-> int'(wait_ff) >= N_LO && int'(wait_ff) <= N_HI;
    endproperty
    a_done_time: assert property (p_done_time) else $error("record done at wrong cycle");
    property p_end_gate; s_done_rise |-> $past(i_boot_end, 14); endproperty
    a_end_gate: assert property (p_end_gate) else $error("record before loader end");
    property p_done_hold; o_boot_complete_flag |=> o_boot_complete_flag; endproperty
    a_done_hold: assert property (p_done_hold) else $error("done flag dropped");
    property p_fail_hold; o_boot_failed_flag |=> o_boot_failed_flag; endproperty
    a_fail_hold: assert property (p_fail_hold) else $error("fail flag dropped");
    property p_fail_with_done; $rose(o_boot_failed_flag) |-> s_done_rise; endproperty
    a_fail_with_done: assert property (p_fail_with_done) else $error("fail before record");
    property p_fail_cause; s_done_rise |-> o_boot_failed_flag == (i_pin0
        || (|i_factory_load_error) || i_later_user_block_error || i_first_user_block_error);
    endproperty
    a_fail_cause: assert property (p_fail_cause) else $error("fail flag wrong");
    property p_run_delay; s_done_rise ##0 i_mission_level |=> o_cpu_run; endproperty
    a_run_delay: assert property (p_run_delay) else $error("run late");
    property p_run_mission; $rose(o_cpu_run) |-> i_mission_level; endproperty
    a_run_mission: assert property (p_run_mission) else $error("run without mission");
    property p_run_after; o_cpu_run |-> $past(o_boot_complete_flag); endproperty
    a_run_after: assert property (p_run_after) else $error("run before record");
    property p_start_zero; o_cpu_run |-> o_cpu_start_addr == BSR_CPU_START_ADDR; endproperty
    a_start_zero: assert property (p_start_zero) else $error("start address wrong");
endmodule
bind bsr_top bsr_top_chk #(.FACTORY_BYTES(FACTORY_BYTES)) chk_u (.i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst), .i_pin0(i_pin0), .i_mission_level(i_mission_level),
    .i_boot_end(i_boot_end),
    .i_factory_load_error(i_factory_load_error), .o_cpu_run(o_cpu_run),
    .i_later_user_block_error(i_later_user_block_error), .o_cpu_start_addr(o_cpu_start_addr),
    .i_first_user_block_error(i_first_user_block_error), .o_boot_failed_flag(o_boot_failed_flag),
    .o_boot_complete_flag(o_boot_complete_flag));
`default_nettype wire

// >>> sim/bsr_cpu_model.sv
// Processor core model: data and fetch reads, data writes once released
`default_nettype none
module bsr_cpu_model (
    input wire logic i_sys_clk,
    input wire logic i_run,
    input wire logic [7:0] i_rdata,
    input wire logic [7:0] i_fetch_data,
    output logic o_we = 1'b0,
    output logic [12:0] o_addr = 13'h0000,
    output logic [7:0] o_wdata = 8'h00,
    output logic [12:0] o_fetch_addr = 13'h0000
);
    timeunit 1ns;
    timeprecision 1ns;
    // Address held two edges: one for the RAM flop, one to sample settled data
    task automatic rd(input logic [12:0] a, input logic fetch, output logic [7:0] d);
        @(posedge i_sys_clk);
        if (fetch) o_fetch_addr <= a;
        else o_addr <= a;
        repeat (2) @(posedge i_sys_clk);
        d = fetch ? i_fetch_data : i_rdata;
    endtask
    // user code acts only after release
    task automatic wr(input logic [12:0] a, input logic [7:0] v);
        wait (i_run === 1'b1);
        @(posedge i_sys_clk);
        o_we <= 1'b1;
        o_addr <= a;
        o_wdata <= v;
        @(posedge i_sys_clk);
        o_we <= 1'b0;
        o_wdata <= ~v;
    endtask
endmodule
`default_nettype wire

// >>> sim/bsr_top_tb_top.sv
// Self-checking bench for the boot status record block
`default_nettype none
module bsr_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [12:0] RSV = 13'h11e3;
    typedef struct packed {
        logic pin;
        logic [2:0] ferr;
        logic lat;
        logic fst;
        logic mis;
        logic [15:0] us;
        logic [15:0] nx;
        logic [7:0] res;
    } bsr_row_type;
    // Last row is a mission part so the processor runs for the later tests
    bsr_row_type rows [6] = '{
        '{1'b0, 3'h0, 1'b0, 1'b0, 1'b1, 16'h0120, 16'h0345, 8'h00},
        '{1'b1, 3'h0, 1'b0, 1'b0, 1'b1, 16'h0200, 16'h1fff, 8'h80},
        '{1'b0, 3'h5, 1'b0, 1'b0, 1'b1, 16'h00ff, 16'h0100, 8'h14},
        '{1'b1, 3'h7, 1'b1, 1'b1, 1'b0, 16'hffff, 16'h0000, 8'h9f},
        '{1'b0, 3'h0, 1'b1, 1'b0, 1'b1, 16'h8001, 16'h7ffe, 8'h02},
        '{1'b0, 3'h0, 1'b0, 1'b1, 1'b1, 16'h1234, 16'h1ed0, 8'h01}};
    logic [12:0] adr [7] = '{13'h11f3, 13'h11f4, 13'h11f5, 13'h11f6, 13'h11fd, 13'h11fe, 13'h11ff};
    logic i_sys_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_fill_we = 1'b0;
    logic i_boot_end = 1'b1;
    logic [12:0] i_fill_addr = 13'h0000;
    logic [7:0] i_fill_data = 8'h00;
    logic cpu_we, run, done, failed;
    logic [12:0] daddr, faddr, start;
    logic [7:0] wdata, rdata, fdata, d;
    logic [55:0] exp;
    bsr_row_type r = '0;
    int failures = 0;
    int n_compared = 0;
    int cyc = 0;
    bsr_top #(.RESERVED_START(RSV)) dut_u (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
        .i_pin0(r.pin), .i_boot_end(i_boot_end), .i_mission_level(r.mis),
        .i_user_load_nvm_start(r.us), .i_nvm_next_unread(r.nx), .i_factory_load_error(r.ferr),
        .i_later_user_block_error(r.lat),
        .i_first_user_block_error(r.fst), .i_fill_we(i_fill_we), .i_fill_addr(i_fill_addr),
        .i_fill_data(i_fill_data), .i_cpu_we(cpu_we), .i_cpu_data_addr(daddr),
        .i_cpu_wdata(wdata), .i_cpu_fetch_addr(faddr), .o_cpu_rdata(rdata),
        .o_cpu_fetch_data(fdata), .o_boot_failed_flag(failed), .o_boot_complete_flag(done),
        .o_cpu_run(run), .o_cpu_start_addr(start));
    bsr_cpu_model cpu_u (.i_sys_clk(i_sys_clk), .i_run(run), .i_rdata(rdata),
        .i_fetch_data(fdata), .o_we(cpu_we), .o_addr(daddr), .o_wdata(wdata), .o_fetch_addr(faddr));
    initial forever #10 i_sys_clk = ~i_sys_clk;
    task automatic chk(input logic [15:0] seen, input logic [15:0] want, input string m);
        n_compared++;
        if (seen !== want) begin
            failures++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, m, seen, want);
        end
    endtask
    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Inputs stay steady through reset so the early pin sample is well defined
    task automatic boot(input bsr_row_type x);
        @(posedge i_sys_clk);
        i_sys_rst <= 1'b1;
        r <= x;
        repeat (4) @(posedge i_sys_clk);
        chk(done, 1'b0, "done in reset");
        i_sys_rst <= 1'b0;
        for (int k = 0; k < 100 && done !== 1'b1; k++) @(negedge i_sys_clk);
        @(negedge i_sys_clk);
    endtask
    initial begin
        for (int i = 0; i < 6; i++) begin
            boot(rows[i]);
            chk(failed, rows[i].res != 8'h00, "fail flag");
            chk(run, rows[i].mis, "run");
            chk(start, 13'h0000, "start address");
            exp = {3'h0, RSV, rows[i].us, rows[i].nx, rows[i].res};
            for (int k = 0; k < 7; k++) begin
                cpu_u.rd(adr[k], 1'b0, d);
                chk(d, exp[55-8*k -: 8], "record byte");
            end
            cpu_u.rd(13'h11ff, 1'b1, d);
            chk(d, rows[i].res, "fetch port");
            $display("row %0d done", i);
        end
        // Loader write after the record must not land
        @(posedge i_sys_clk);
        i_fill_we <= 1'b1;
        i_fill_addr <= 13'h11ff;
        i_fill_data <= 8'hff;
        @(posedge i_sys_clk);
        i_fill_we <= 1'b0;
        cpu_u.rd(13'h11ff, 1'b0, d);
        chk(d, 8'h01, "late loader write");
        cpu_u.wr(13'h0010, 8'h3c);
        cpu_u.rd(13'h0010, 1'b1, d);
        chk(d, 8'h3c, "fetch after write");
        // deliberate overwrite of the reserved area, then reset
        cpu_u.wr(RSV, 8'h00);
        cpu_u.rd(RSV, 1'b0, d);
        chk(d, 8'h00, "reserved area writable");
        boot(rows[0]);
        cpu_u.rd(RSV, 1'b0, d);
        chk(d, RSV[7:0] ^ 8'h5a, "reserved restored");
        // Record must wait while the loader has not finished
        @(posedge i_sys_clk);
        i_boot_end <= 1'b0;
        boot(rows[2]);
        chk(done, 1'b0, "record before loader end");
        @(posedge i_sys_clk);
        i_boot_end <= 1'b1;
        for (int k = 0; k < 40 && done !== 1'b1; k++) @(negedge i_sys_clk);
        chk(done, 1'b1, "record after loader end");
        cpu_u.rd(13'h11ff, 1'b0, d);
        chk(d, rows[2].res, "result after loader end");
        $display("hand tests done");
        close_out();
    end
    // Whole run needs about 550 cycles
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            close_out();
        end
    end
endmodule
`default_nettype wire
